// *** rtl/msc_pkg.sv ***
// Shared constants, field layouts and types of the modem sync control bank
package msc_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register indices; byte address is four times the index
    localparam int ADDR_W = 12;
    localparam int IDX_W = 10;
    localparam logic [IDX_W-1:0] IDX_CTRL_A = 10'h046;
    localparam logic [IDX_W-1:0] IDX_CTRL_B = 10'h047;
    localparam logic [IDX_W-1:0] IDX_EST = 10'h048;
    localparam logic [IDX_W-1:0] IDX_TUNE_A = 10'h05a;
    localparam logic [IDX_W-1:0] IDX_TEST_B = 10'h05b;
    localparam int IDX_LSB = 2;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values and writable-bit masks
    localparam logic [7:0] RST_CTRL_A = 8'h45;
    localparam logic [7:0] RST_CTRL_B = 8'h2e;
    localparam logic [7:0] RST_EST = 8'h00;
    localparam logic [7:0] RST_TUNE_A = 8'h05;
    localparam logic [7:0] RST_TEST_B = 8'h08;
    localparam logic [7:0] MASK_CTRL_B = 8'h3f;
    localparam logic [7:0] MASK_TEST_B = 8'h0f;

    ////////////////////////////////////////////////////////////////////////////
    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [23:0] RDATA_PAD = 24'h00_0000;

    ////////////////////////////////////////////////////////////////////////////
    // Symbol codes, preamble and averaging constants
    localparam logic [3:0] ZERO_SYM = 4'h0;
    localparam logic [3:0] SFD_SYM_LO = 4'h7;
    localparam logic [3:0] SFD_SYM_HI = 4'ha;
    localparam logic [5:0] LEAD_BASE_BYTES = 6'h02;
    localparam logic [5:0] TX_CNT_LAST = 6'h01;
    localparam logic [1:0] ZEROS_MAX = 2'h3;
    localparam logic [1:0] ZEROS_ONE = 2'h1;
    localparam logic [1:0] ZEROS_RSVD = 2'h0;
    localparam int AVG_FRAC = 2;
    localparam int AVG_GAIN_SHIFT = 2;
    localparam int FREQ_STEP_HZ = 7800;

    ////////////////////////////////////////////////////////////////////////////
    // Register field layouts
    typedef struct packed {
        logic [1:0] sync_zero_count;
        logic averaging_select;
        logic [3:0] lead_bytes;
        logic tx_shaping;
    } msc_ctrl_a_t;

    typedef struct packed {
        logic [1:0] rsvd;
        logic sfd_correlation_rule;
        logic [4:0] correlation_limit;
    } msc_ctrl_b_t;

    typedef struct packed {
        logic [3:0] rsvd;
        logic keep_hi;
        logic frame_observe_enable;
        logic phase_reverse;
        logic keep_lo;
    } msc_test_b_t;

    // One received symbol from the correlator
    typedef struct packed {
        logic valid;
        logic [3:0] code;
        logic [4:0] corr;
    } msc_sym_t;

    typedef enum logic [1:0] {TX_IDLE, TX_LEAD, TX_SFD0, TX_SFD1} msc_tx_phase_t;
    typedef enum logic {SD_HUNT, SD_SFD1} msc_sd_phase_t;

endpackage

// *** rtl/msc_sync_detect.sv ***
// Zero-symbol and SFD search of the receive correlator stream
`timescale 1ns/1ps
module msc_sync_detect (
    // Clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // Settings
    input wire logic demod_en,
    input wire logic [1:0] sync_zero_count,
    input wire logic sfd_correlation_rule,
    input wire logic [4:0] correlation_limit,
    // Symbols and result
    input wire msc_pkg::msc_sym_t rx_sym,
    output logic sync_found
);

    typedef struct packed {
        msc_pkg::msc_sd_phase_t phase;
        logic [1:0] zeros;
        logic hit;
        logic found;
    } msc_sd_st_t;

    msc_sd_st_t s;
    msc_sd_st_t next_s;
    logic above;
    logic [1:0] need;

    always_comb begin
        above = rx_sym.corr > correlation_limit;
        // Reserved code behaves as one zero symbol
        need = (sync_zero_count == msc_pkg::ZEROS_RSVD) ? msc_pkg::ZEROS_ONE
                                                       : sync_zero_count;
        next_s = s;
        next_s.found = 1'b0;
        if (!demod_en) begin
            next_s.phase = msc_pkg::SD_HUNT;
            next_s.zeros = '0;
            next_s.hit = 1'b0;
        end else if (rx_sym.valid) begin
            case (s.phase)
                msc_pkg::SD_HUNT: begin
                    if (rx_sym.code == msc_pkg::ZERO_SYM) begin
                        if (s.zeros != msc_pkg::ZEROS_MAX) begin
                            next_s.zeros = s.zeros + 2'h1;
                        end
                        next_s.hit = s.hit | above;
                    end else begin
                        if (rx_sym.code == msc_pkg::SFD_SYM_LO && s.zeros >= need && s.hit
                            && (!sfd_correlation_rule || above)) begin
                            next_s.phase = msc_pkg::SD_SFD1;
                        end
                        next_s.zeros = '0;
                        next_s.hit = 1'b0;
                    end
                end
                msc_pkg::SD_SFD1: begin
                    next_s.found = rx_sym.code == msc_pkg::SFD_SYM_HI
                                   && (!sfd_correlation_rule || above);
                    next_s.phase = msc_pkg::SD_HUNT;
                end
                default: begin
                    next_s.phase = msc_pkg::SD_HUNT;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            s <= '{phase: msc_pkg::SD_HUNT, zeros: 2'h0, hit: 1'b0, found: 1'b0};
        end else begin
            s <= next_s;
        end
    end

    assign sync_found = s.found;

    property p_sync_needs_sfd;
        @(posedge clock) disable iff (!arst_n)
        sync_found |-> $past(s.phase == msc_pkg::SD_SFD1) && $past(rx_sym.code)
            == msc_pkg::SFD_SYM_HI;
    endproperty
    a_sync_needs_sfd: assert property (p_sync_needs_sfd) else $error("sync without SFD");

    property p_sfd_needs_hit;
        @(posedge clock) disable iff (!arst_n)
        (s.phase == msc_pkg::SD_HUNT && rx_sym.valid && demod_en && !s.hit)
            |=> s.phase == msc_pkg::SD_HUNT;
    endproperty
    a_sfd_needs_hit: assert property (p_sfd_needs_hit) else $error("SFD search without hit");

endmodule

// *** rtl/msc_freq_track.sv ***
// Carrier frequency-offset averaging and estimate hold
`timescale 1ns/1ps
module msc_freq_track (
    // Clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // Settings and events
    input wire logic demod_en,
    input wire logic averaging_select,
    input wire logic sync_found,
    input wire logic search_start,
    input wire logic frame_end,
    // Raw offset samples
    input wire logic [7:0] offset_sample,
    input wire logic offset_valid,
    // Estimate
    output logic [7:0] estimate
);

    localparam int AVG_W = 8 + msc_pkg::AVG_FRAC;

    typedef struct packed {
        logic signed [AVG_W-1:0] avg;
        logic primed;
        logic frozen;
    } msc_ft_st_t;

    msc_ft_st_t s;
    msc_ft_st_t next_s;
    logic signed [AVG_W-1:0] scaled;
    logic signed [AVG_W:0] diff;

    always_comb begin
        scaled = AVG_W'(signed'({offset_sample, {msc_pkg::AVG_FRAC{1'b0}}}));
        diff = (AVG_W+1)'(scaled) - (AVG_W+1)'(s.avg);
        next_s = s;
        if (search_start || frame_end) begin
            next_s.frozen = 1'b0;
        end
        if (search_start) begin
            next_s.primed = 1'b0;
        end
        if (sync_found && !averaging_select) begin
            next_s.frozen = 1'b1;
        end else if (demod_en && offset_valid && !s.frozen) begin
            next_s.primed = 1'b1;
            if (!s.primed || search_start) begin
                next_s.avg = scaled;
            end else begin
                next_s.avg = s.avg + AVG_W'(diff >>> msc_pkg::AVG_GAIN_SHIFT);
            end
        end
        if (averaging_select) begin
            next_s.frozen = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            s <= '{avg: '0, primed: 1'b0, frozen: 1'b0};
        end else begin
            s <= next_s;
        end
    end

    assign estimate = s.avg[AVG_W-1:msc_pkg::AVG_FRAC];

    property p_hold_while_frozen;
        @(posedge clock) disable iff (!arst_n)
        (s.frozen && !averaging_select) ##1 (s.frozen && !averaging_select)
            |-> $stable(estimate);
    endproperty
    a_hold_while_frozen: assert property (p_hold_while_frozen) else $error("estimate moved");

    property p_continuous;
        @(posedge clock) disable iff (!arst_n)
        averaging_select |=> !s.frozen;
    endproperty
    a_continuous: assert property (p_continuous) else $error("froze in continuous mode");

endmodule

// *** rtl/msc_regs.sv ***
// Modem sync control register bank with AXI4-Lite slave and preamble sender
`timescale 1ns/1ps
module msc_regs (
    // Clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // AXI4-Lite write address and data
    input wire logic [msc_pkg::ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // AXI4-Lite write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read
    input wire logic [msc_pkg::ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Demodulator side
    input wire logic demod_en,
    input wire msc_pkg::msc_sym_t rx_sym,
    input wire logic [7:0] offset_sample,
    input wire logic offset_valid,
    input wire logic search_start,
    input wire logic frame_end,
    output logic sync_found,
    // Transmit symbol stream
    input wire logic tx_start,
    input wire logic tx_sym_ready,
    output logic tx_sym_valid,
    output logic [3:0] tx_sym,
    // Modem settings
    output logic tx_extra_filter,
    output logic phase_reverse,
    // Frame observe pins
    output logic observe_valid,
    output logic observe_is_tx,
    output logic [3:0] observe_sym
);

    ////////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        msc_pkg::msc_ctrl_a_t ctrl_a;
        msc_pkg::msc_ctrl_b_t ctrl_b;
        logic [7:0] tune_a;
        msc_pkg::msc_test_b_t test_b;
        logic aw_have;
        logic [msc_pkg::IDX_W-1:0] aw_idx;
        logic w_have;
        logic [7:0] w_byte;
        logic w_lane;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [7:0] rbyte;
        logic [1:0] rresp;
        msc_pkg::msc_tx_phase_t tx_phase;
        logic [5:0] tx_cnt;
        logic [3:0] tx_sym;
        logic obs_valid;
        logic obs_tx;
        logic [3:0] obs_sym;
    } msc_top_st_t;

    msc_top_st_t s;
    msc_top_st_t next_s;
    logic [7:0] estimate;
    logic [msc_pkg::IDX_W-1:0] ar_idx;
    logic [7:0] rd_val;
    logic rd_hit;
    logic wr_hit;
    logic tx_take;

    ////////////////////////////////////////////////////////////////////////////
    // Receive path helpers

    msc_sync_detect u_sync (
        .clock(clock),
        .arst_n(arst_n),
        .demod_en(demod_en),
        .sync_zero_count(s.ctrl_a.sync_zero_count),
        .sfd_correlation_rule(s.ctrl_b.sfd_correlation_rule),
        .correlation_limit(s.ctrl_b.correlation_limit),
        .rx_sym(rx_sym),
        .sync_found(sync_found)
    );

    msc_freq_track u_freq (
        .clock(clock),
        .arst_n(arst_n),
        .demod_en(demod_en),
        .averaging_select(s.ctrl_a.averaging_select),
        .sync_found(sync_found),
        .search_start(search_start),
        .frame_end(frame_end),
        .offset_sample(offset_sample),
        .offset_valid(offset_valid),
        .estimate(estimate)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        next_s = s;
        ar_idx = araddr[msc_pkg::ADDR_W-1:msc_pkg::IDX_LSB];
        tx_take = tx_sym_valid && tx_sym_ready;

        // Read decode; reading has no side effect
        rd_hit = 1'b1;
        case (ar_idx)
            msc_pkg::IDX_CTRL_A: rd_val = s.ctrl_a;
            msc_pkg::IDX_CTRL_B: rd_val = s.ctrl_b;
            msc_pkg::IDX_EST: rd_val = estimate;
            msc_pkg::IDX_TUNE_A: rd_val = s.tune_a;
            msc_pkg::IDX_TEST_B: rd_val = s.test_b;
            default: begin
                rd_val = '0;
                rd_hit = 1'b0;
            end
        endcase

        // Write address and data, taken in either order
        if (awvalid && awready) begin
            next_s.aw_have = 1'b1;
            next_s.aw_idx = awaddr[msc_pkg::ADDR_W-1:msc_pkg::IDX_LSB];
        end
        if (wvalid && wready) begin
            next_s.w_have = 1'b1;
            next_s.w_byte = wdata[7:0];
            next_s.w_lane = wstrb[0];
        end

        wr_hit = 1'b1;
        if (s.aw_have && s.w_have) begin
            case (s.aw_idx)
                msc_pkg::IDX_CTRL_A: begin
                    if (s.w_lane) begin
                        next_s.ctrl_a = s.w_byte;
                    end
                end
                msc_pkg::IDX_CTRL_B: begin
                    if (s.w_lane) begin
                        next_s.ctrl_b = s.w_byte & msc_pkg::MASK_CTRL_B;
                    end
                end
                msc_pkg::IDX_EST: begin
                    wr_hit = 1'b1;
                end
                msc_pkg::IDX_TUNE_A: begin
                    if (s.w_lane) begin
                        next_s.tune_a = s.w_byte;
                    end
                end
                msc_pkg::IDX_TEST_B: begin
                    if (s.w_lane) begin
                        next_s.test_b = s.w_byte & msc_pkg::MASK_TEST_B;
                    end
                end
                default: begin
                    wr_hit = 1'b0;
                end
            endcase
            next_s.aw_have = 1'b0;
            next_s.w_have = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp = wr_hit ? msc_pkg::RESP_OKAY : msc_pkg::RESP_SLVERR;
        end else if (s.bvalid && bready) begin
            next_s.bvalid = 1'b0;
        end

        // Read answer one cycle after the address
        if (arvalid && arready) begin
            next_s.rvalid = 1'b1;
            next_s.rbyte = rd_val;
            next_s.rresp = rd_hit ? msc_pkg::RESP_OKAY : msc_pkg::RESP_SLVERR;
        end else if (s.rvalid && rready) begin
            next_s.rvalid = 1'b0;
        end

        // Preamble and SFD sender
        case (s.tx_phase)
            msc_pkg::TX_IDLE: begin
                if (tx_start) begin
                    next_s.tx_phase = msc_pkg::TX_LEAD;
                    next_s.tx_cnt = (6'(s.ctrl_a.lead_bytes) + msc_pkg::LEAD_BASE_BYTES)
                                    << 1;
                    next_s.tx_sym = msc_pkg::ZERO_SYM;
                end
            end
            msc_pkg::TX_LEAD: begin
                if (tx_take) begin
                    next_s.tx_cnt = s.tx_cnt - 6'h01;
                    if (s.tx_cnt == msc_pkg::TX_CNT_LAST) begin
                        next_s.tx_phase = msc_pkg::TX_SFD0;
                        next_s.tx_sym = msc_pkg::SFD_SYM_LO;
                    end
                end
            end
            msc_pkg::TX_SFD0: begin
                if (tx_take) begin
                    next_s.tx_phase = msc_pkg::TX_SFD1;
                    next_s.tx_sym = msc_pkg::SFD_SYM_HI;
                end
            end
            msc_pkg::TX_SFD1: begin
                if (tx_take) begin
                    next_s.tx_phase = msc_pkg::TX_IDLE;
                    next_s.tx_sym = msc_pkg::ZERO_SYM;
                end
            end
            default: begin
                next_s.tx_phase = msc_pkg::TX_IDLE;
            end
        endcase

        // Observe pins, transmit wins a shared cycle
        next_s.obs_valid = s.test_b.frame_observe_enable && (tx_take || rx_sym.valid);
        if (tx_take) begin
            next_s.obs_tx = 1'b1;
            next_s.obs_sym = s.tx_sym;
        end else if (rx_sym.valid) begin
            next_s.obs_tx = 1'b0;
            next_s.obs_sym = rx_sym.code;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            s <= '0;
            s.ctrl_a <= msc_pkg::RST_CTRL_A;
            s.ctrl_b <= msc_pkg::RST_CTRL_B;
            s.tune_a <= msc_pkg::RST_TUNE_A;
            s.test_b <= msc_pkg::RST_TEST_B;
            s.tx_phase <= msc_pkg::TX_IDLE;
        end else begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign awready = !s.aw_have && !s.bvalid;
    assign wready = !s.w_have && !s.bvalid;
    assign bvalid = s.bvalid;
    assign bresp = s.bresp;
    assign arready = !s.rvalid;
    assign rvalid = s.rvalid;
    assign rresp = s.rresp;
    assign rdata = {msc_pkg::RDATA_PAD, s.rbyte};
    assign tx_sym_valid = s.tx_phase != msc_pkg::TX_IDLE;
    assign tx_sym = s.tx_sym;
    assign tx_extra_filter = s.ctrl_a.tx_shaping;
    assign phase_reverse = s.test_b.phase_reverse;
    assign observe_valid = s.obs_valid;
    assign observe_is_tx = s.obs_tx;
    assign observe_sym = s.obs_sym;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    property p_lead_len;
        @(posedge clock) disable iff (!arst_n)
        (s.tx_phase == msc_pkg::TX_IDLE && tx_start)
            |=> s.tx_cnt == 6'(($past(s.ctrl_a.lead_bytes) + 4'h2) * 2);
    endproperty
    a_lead_len: assert property (p_lead_len) else $error("wrong lead length");

    property p_sfd_follows;
        @(posedge clock) disable iff (!arst_n)
        (s.tx_phase == msc_pkg::TX_LEAD && tx_take && s.tx_cnt == 6'h01)
            |=> tx_sym_valid && tx_sym == msc_pkg::SFD_SYM_LO;
    endproperty
    a_sfd_follows: assert property (p_sfd_follows) else $error("SFD not after lead");

    property p_read_quiet;
        @(posedge clock) disable iff (!arst_n)
        (arvalid && arready && !(s.aw_have && s.w_have))
            |=> $stable(s.ctrl_a) && $stable(s.ctrl_b) && $stable(s.test_b);
    endproperty
    a_read_quiet: assert property (p_read_quiet) else $error("read changed state");

    property p_rsvd_zero;
        @(posedge clock) disable iff (!arst_n)
        s.ctrl_b.rsvd == 2'h0 && s.test_b.rsvd == 4'h0;
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits set");

    property p_observe_gate;
        @(posedge clock) disable iff (!arst_n)
        observe_valid |-> $past(s.test_b.frame_observe_enable);
    endproperty
    a_observe_gate: assert property (p_observe_gate) else $error("observe while off");

endmodule

// *** testbench/msc_regs_bench.sv ***
// Self-checking bench of the modem sync control register bank
`timescale 1ns/1ps
module msc_regs_bench;
    localparam logic [7:0] RV [5] = '{8'h45, 8'h2e, 8'h00, 8'h05, 8'h08};
    localparam logic [9:0] IX [5] = '{10'h046, 10'h047, 10'h048, 10'h05a, 10'h05b};
    logic clock = 0;
    logic arst_n = 0;
    logic [11:0] awaddr = '0, araddr = '0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [31:0] wdata = '0;
    logic [3:0] wstrb = '0;
    logic awready, wready, bvalid, arready, rvalid, sync_found, tx_sym_valid;
    logic tx_extra_filter, phase_reverse, observe_valid, observe_is_tx;
    logic [1:0] bresp, rresp, r;
    logic [31:0] rdata, d;
    logic [3:0] tx_sym, observe_sym;
    logic demod_en = 0, offset_valid = 0, search_start = 0, frame_end = 0;
    logic tx_start = 0, tx_sym_ready = 0;
    logic [7:0] offset_sample = '0, v;
    msc_pkg::msc_sym_t rx_sym = '0;
    int mismatches = 0, checks = 0, syncs = 0, obs_n = 0, obs_sum = 0;

    msc_regs dut_u (.clock(clock), .arst_n(arst_n), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .demod_en(demod_en), .rx_sym(rx_sym), .offset_sample(offset_sample),
        .offset_valid(offset_valid), .search_start(search_start), .frame_end(frame_end),
        .sync_found(sync_found), .tx_start(tx_start), .tx_sym_ready(tx_sym_ready),
        .tx_sym_valid(tx_sym_valid), .tx_sym(tx_sym), .tx_extra_filter(tx_extra_filter),
        .phase_reverse(phase_reverse), .observe_valid(observe_valid),
        .observe_is_tx(observe_is_tx), .observe_sym(observe_sym));

    initial begin
        forever #10 clock = ~clock;
    end
    always @(posedge clock) begin
        if (sync_found === 1'b1) syncs++;
        if (observe_valid === 1'b1) obs_n++;
        if (observe_valid === 1'b1) obs_sum += observe_is_tx ? int'(observe_sym) : 100;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    // Handshakes are judged from values held steady at the falling edge;
    // bready and rready stay high between transfers
    task automatic wr(input logic [9:0] i, input logic [7:0] x);
        logic ha, hw, hb;
        awaddr <= {i, 2'b00};
        wdata <= {24'h00_0000, x};
        wstrb <= 4'h1;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        for (int n = 0; n < 40; n++) begin
            @(negedge clock);
            ha = awvalid && awready;
            hw = wvalid && wready;
            hb = bvalid;
            r = bresp;
            @(posedge clock);
            if (ha) awvalid <= 0;
            if (hw) wvalid <= 0;
            if (hb) begin
                return;
            end
        end
        mismatches++;
        wrap_up();
    endtask
    task automatic rd(input logic [9:0] i);
        logic ha, hr;
        araddr <= {i, 2'b00};
        arvalid <= 1;
        rready <= 1;
        for (int n = 0; n < 40; n++) begin
            @(negedge clock);
            ha = arvalid && arready;
            hr = rvalid;
            d = rdata;
            r = rresp;
            @(posedge clock);
            if (ha) arvalid <= 0;
            if (hr) begin
                return;
            end
        end
        mismatches++;
        wrap_up();
    endtask
    task automatic send(input logic [3:0] c, input logic [4:0] k);
        rx_sym <= {1'b1, c, k};
        @(posedge clock);
    endtask
    function automatic logic [3:0] tx_exp(input int lead, input int k);
        return k < (lead + 2) * 2 ? 4'h0 : k == (lead + 2) * 2 ? 4'h7 : 4'ha;
    endfunction
    function automatic logic exp_sync(input int need, input int got, input logic rl,
            input logic ok);
        return got >= need && (!rl || ok);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        int lead, need, got, s0, o0, q0;
        logic rl, ok;
        void'($urandom(17353));
        repeat (4) @(posedge clock);
        arst_n <= 1;
        @(posedge clock);
        demod_en <= 1;
        for (int k = 0; k < 5; k++) begin
            rd(IX[k]);
            chk("reset value", {24'h00_0000, RV[k]}, d);
        end
        chk("filter pin at reset", 1, tx_extra_filter);
        $display("test reset done");
        v = 8'($urandom);
        wr(IX[0], v);
        rd(IX[0]);
        chk("control a", v, d);
        chk("filter pin", v[0], tx_extra_filter);
        v = 8'($urandom);
        wr(IX[1], v);
        rd(IX[1]);
        chk("control b", v & 8'h3f, d);
        v = 8'h08 | (8'($urandom) & 8'hf6);
        wr(IX[4], v);
        rd(IX[4]);
        chk("test b", v & 8'h0f, d);
        chk("phase pin", v[1], phase_reverse);
        wr(IX[2], 8'hff);
        chk("estimate write resp", 0, r);
        rd(IX[2]);
        chk("estimate write ignored", 0, d);
        wr(10'h049, 8'h5a);
        chk("unmapped write resp", 2, r);
        rd(10'h049);
        chk("unmapped read resp", 2, r);
        chk("unmapped read data", 0, d);
        $display("test registers done");
        wr(IX[4], 8'h0c);
        for (int t = 0; t < 3; t++) begin
            lead = t == 0 ? 0 : t == 1 ? 15 : $urandom % 16;
            wr(IX[0], {2'b10, 1'b1, 4'(lead), 1'b0});
            o0 = obs_n;
            q0 = obs_sum;
            tx_start <= 1;
            @(posedge clock);
            tx_start <= 0;
            got = 0;
            for (int n = 0; n < 400 && got < (lead + 2) * 2 + 2; n++) begin
                tx_sym_ready <= 1'($urandom);
                @(negedge clock);
                if (tx_sym_valid && tx_sym_ready) begin
                    chk("tx symbol", tx_exp(lead, got), tx_sym);
                    got++;
                end
                @(posedge clock);
            end
            tx_sym_ready <= 0;
            repeat (2) @(negedge clock);
            chk("tx count", (lead + 2) * 2 + 2, got);
            chk("tx idle", 0, tx_sym_valid);
            chk("observe count", (lead + 2) * 2 + 2, obs_n - o0);
            chk("observe symbols", 17, obs_sum - q0);
            @(posedge clock);
        end
        $display("test transmit done");
        for (int t = 0; t < 10; t++) begin
            need = $urandom % 4;
            got = $urandom % 4;
            rl = 1'($urandom);
            ok = 1'($urandom);
            wr(IX[0], {2'(need), 1'b1, 4'h2, 1'b1});
            wr(IX[1], {2'b00, rl, 5'h14});
            need = need == 0 ? 1 : need;
            s0 = syncs;
            send(4'h3, 5'h00);
            for (int z = 0; z < got; z++) send(4'h0, z == 0 ? 5'h15 : 5'h14);
            send(4'h7, ok ? 5'h15 : 5'h14);
            send(4'ha, ok ? 5'h15 : 5'h14);
            rx_sym <= '0;
            repeat (3) @(posedge clock);
            chk("sync pulses", exp_sync(need, got, rl, ok), syncs - s0);
        end
        $display("test sync done");
        wr(IX[0], 8'h65);
        v = 8'($urandom);
        search_start <= 1;
        @(posedge clock);
        search_start <= 0;
        offset_sample <= v;
        offset_valid <= 1;
        @(posedge clock);
        offset_valid <= 0;
        repeat (2) @(posedge clock);
        rd(IX[2]);
        chk("estimate", v, d);
        rd(IX[2]);
        chk("estimate reread", v, d);
        wr(IX[0], 8'h85);
        wr(IX[1], 8'h14);
        wr(IX[4], 8'h08);
        o0 = obs_n;
        s0 = syncs;
        send(4'h0, 5'h15);
        send(4'h0, 5'h14);
        send(4'h7, 5'h14);
        send(4'ha, 5'h14);
        rx_sym <= '0;
        @(posedge clock);
        offset_sample <= 8'(~v);
        offset_valid <= 1;
        @(posedge clock);
        offset_valid <= 0;
        rd(IX[2]);
        chk("estimate frozen", v, d);
        chk("sync in mode 0", 1, syncs - s0);
        chk("observe off", o0, obs_n);
        search_start <= 1;
        @(posedge clock);
        search_start <= 0;
        offset_valid <= 1;
        @(posedge clock);
        offset_valid <= 0;
        rd(IX[2]);
        chk("estimate restart", 8'(~v), d);
        $display("test estimate done");
        wrap_up();
    end
endmodule
